// >>> hw/ssmc_pkg.sv
package ssmc_pkg;

  // Decoded supervisor operating state
  typedef enum logic [1:0] {
    SSMC_OFF    = 2'h0,
    SSMC_NORMAL = 2'h1,
    SSMC_FULL   = 2'h2
  } ssmc_state_t;

  // Power mode encoding at the mode input
  typedef enum logic [1:0] {
    SSMC_PM_ACTIVE = 2'h0,
    SSMC_PM_LPM01  = 2'h1,
    SSMC_PM_LPM234 = 2'h2
  } ssmc_pmode_t;

  // Clock rate in kHz and wakeup hold time in microseconds
  localparam int unsigned CLK_KHZ        = 40000;
  localparam int unsigned SLOW_WAKE_US   = 150;
  localparam int unsigned SLOW_WAKE_CYC  = SLOW_WAKE_US * CLK_KHZ / 1000;
  // Settling delay after a control write, in microseconds
  localparam int unsigned SETTLE_US      = 150;
  localparam int unsigned SETTLE_CYC     = SETTLE_US * CLK_KHZ / 1000;
  localparam int unsigned CNT_W          = 16;

endpackage

// >>> hw/ssmc_top.sv
`timescale 1ns/10ps
// Overview of operation
// - Fast wakeup when low side off or full-perf
// - Slow wakeup when low side normal
// - Slow wakeup holds core about 150 us
// - Active/LPM0/1 decode: off, normal, full
// - LPM2/3/4 decode via lpm-keep and auto bits
// - Control write raises both settle flags
// - Overvoltage enable makes monitor raise reset
// - High auto control idles monitor in LPM2/3/4
// - Low-side event gives reset or interrupt
module ssmc_top
  import ssmc_pkg::*;
#(
  parameter int unsigned SLOW_CYC   = ssmc_pkg::SLOW_WAKE_CYC,
  parameter int unsigned SETTLE_LEN = ssmc_pkg::SETTLE_CYC
) (
  input  wire logic                  clk_sys,
  input  wire logic                  arst_n,
  input  wire ssmc_pkg::ssmc_pmode_t power_mode,
  input  wire logic                  low_sup_enable,
  input  wire logic                  low_sup_lpm_keep,
  input  wire logic                  low_sup_full_perf,
  input  wire logic                  low_mon_enable,
  input  wire logic                  low_mon_full_perf,
  input  wire logic                  low_auto_control,
  input  wire logic                  high_sup_enable,
  input  wire logic                  high_sup_lpm_keep,
  input  wire logic                  high_sup_full_perf,
  input  wire logic                  high_mon_enable,
  input  wire logic                  high_mon_full_perf,
  input  wire logic                  high_auto_control,
  input  wire logic                  overvoltage_prot_enable,
  input  wire logic                  ctl_write,
  input  wire logic                  wake_req,
  input  wire logic                  low_event,
  input  wire logic                  high_over_event,
  input  wire logic                  low_event_reset_sel,
  output logic [1:0]                 low_sup_state,
  output logic [1:0]                 low_mon_state,
  output logic [1:0]                 high_sup_state,
  output logic [1:0]                 high_mon_state,
  output logic                       slow_wake_sel,
  output logic                       core_resume,
  output logic                       low_settle_flag,
  output logic                       high_settle_flag,
  output logic                       por_req,
  output logic                       low_event_irq
);

  ////////////////////////////////////////////////////////////////////////////
  // Reset release through two flops; async assert, sync release
  logic rst_meta;       // First stage, read only by second
  logic rst_n;          // Released reset used everywhere

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      rst_meta <= 1'b0;
      rst_n    <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n    <= rst_meta;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Active-mode decode of one supervisor or monitor
  function automatic ssmc_state_t am_dec(input logic en, input logic fp);
    if (!en) begin
      am_dec = SSMC_OFF;
    end else if (fp) begin
      am_dec = SSMC_FULL;
    end else begin
      am_dec = SSMC_NORMAL;
    end
  endfunction

  // Deep-mode decode; auto drops state one step
  function automatic ssmc_state_t deep_dec(input ssmc_state_t am, input logic keep,
                                           input logic autoc);
    if (!keep || am == SSMC_OFF) begin
      deep_dec = SSMC_OFF;
    end else if (!autoc) begin
      deep_dec = am;
    end else if (am == SSMC_FULL) begin
      deep_dec = SSMC_NORMAL;
    end else begin
      deep_dec = SSMC_OFF;
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // State decode, registered on every edge
  ssmc_state_t next_low_sup;   // Next low supervisor state
  ssmc_state_t next_low_mon;   // Next low monitor state
  ssmc_state_t next_high_sup;  // Next high supervisor state
  ssmc_state_t next_high_mon;  // Next high monitor state
  logic        next_slow;      // Next slow wakeup select
  logic        deep;           // In LPM2/3/4

  always_comb begin
    deep          = (power_mode == SSMC_PM_LPM234);
    next_low_sup  = am_dec(low_sup_enable, low_sup_full_perf);
    next_low_mon  = am_dec(low_mon_enable, low_mon_full_perf);
    next_high_sup = am_dec(high_sup_enable, high_sup_full_perf);
    next_high_mon = am_dec(high_mon_enable, high_mon_full_perf);
    // Monitors have no lpm-keep bit: they stay on per the table
    if (deep) begin
      next_low_sup  = deep_dec(next_low_sup, low_sup_lpm_keep, low_auto_control);
      next_low_mon  = deep_dec(next_low_mon, 1'b1, low_auto_control);
      next_high_sup = deep_dec(next_high_sup, high_sup_lpm_keep, high_auto_control);
      // Auto control idles the high monitor outright
      if (high_auto_control) begin
        next_high_mon = SSMC_OFF;
      end
    end
    // Slow when a low-side unit is enabled without full-perf, whatever the power mode
    next_slow = (low_sup_enable && !low_sup_full_perf) ||
                (low_mon_enable && !low_mon_full_perf);
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      low_sup_state  <= SSMC_OFF;
      low_mon_state  <= SSMC_OFF;
      high_sup_state <= SSMC_OFF;
      high_mon_state <= SSMC_OFF;
      slow_wake_sel  <= 1'b0;
    end else begin
      low_sup_state  <= next_low_sup;
      low_mon_state  <= next_low_mon;
      high_sup_state <= next_high_sup;
      high_mon_state <= next_high_mon;
      slow_wake_sel  <= next_slow;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Wakeup timer; holds core for the slow path
  logic [CNT_W-1:0] wake_cnt;       // Cycles left before resume
  logic             wake_busy;      // Slow wakeup in progress
  logic [CNT_W-1:0] next_wake_cnt;
  logic             next_wake_busy;
  logic             next_resume;

  always_comb begin
    next_wake_cnt  = wake_cnt;
    next_wake_busy = wake_busy;
    next_resume    = 1'b0;
    if (wake_busy) begin
      if (wake_cnt == CNT_W'(1)) begin
        next_wake_busy = 1'b0;
        next_resume    = 1'b1;
      end
      next_wake_cnt = wake_cnt - CNT_W'(1);
    end else if (wake_req) begin
      if (slow_wake_sel) begin
        next_wake_busy = 1'b1;
        next_wake_cnt  = CNT_W'(SLOW_CYC);
      end else begin
        next_resume = 1'b1;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      wake_cnt    <= '0;
      wake_busy   <= 1'b0;
      core_resume <= 1'b0;
    end else begin
      wake_cnt    <= next_wake_cnt;
      wake_busy   <= next_wake_busy;
      core_resume <= next_resume;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Settle flags: a write restarts the delay, so the set wins
  logic [CNT_W-1:0] settle_cnt;
  logic [CNT_W-1:0] next_settle_cnt;
  logic             next_settle;

  always_comb begin
    next_settle_cnt = settle_cnt;
    if (ctl_write) begin
      next_settle_cnt = CNT_W'(SETTLE_LEN);
    end else if (settle_cnt != '0) begin
      next_settle_cnt = settle_cnt - CNT_W'(1);
    end
    next_settle = (next_settle_cnt != '0);
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      settle_cnt       <= '0;
      low_settle_flag  <= 1'b0;
      high_settle_flag <= 1'b0;
    end else begin
      settle_cnt       <= next_settle_cnt;
      low_settle_flag  <= next_settle;
      high_settle_flag <= next_settle;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Reset and interrupt requests from supervisor events
  logic next_por;
  logic next_irq;
  logic hm_on;   // High monitor currently active

  always_comb begin
    hm_on    = (high_mon_state != SSMC_OFF);
    next_por = (overvoltage_prot_enable && hm_on && high_over_event) ||
               (low_event && low_event_reset_sel);
    next_irq = low_event && !low_event_reset_sel;
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      por_req       <= 1'b0;
      low_event_irq <= 1'b0;
    end else begin
      por_req       <= next_por;
      low_event_irq <= next_irq;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  property p_wake_fast;
    @(posedge clk_sys) disable iff (!rst_n)
    (wake_req && !wake_busy && !slow_wake_sel) |=> core_resume;
  endproperty
  a_wake_fast: assert property (p_wake_fast) else $error("fast wake late");
  property p_wake_slow;
    @(posedge clk_sys) disable iff (!rst_n)
    (wake_req && !wake_busy && slow_wake_sel) |=> !core_resume [*2];
  endproperty
  a_wake_slow: assert property (p_wake_slow) else $error("slow wake early");
  property p_slow_sel;
    @(posedge clk_sys) disable iff (!rst_n)
    (low_sup_enable && !low_sup_full_perf) |=> slow_wake_sel;
  endproperty
  a_slow_sel: assert property (p_slow_sel) else $error("slow not chosen");
  property p_resume_end;
    @(posedge clk_sys) disable iff (!rst_n)
    (wake_busy && wake_cnt == CNT_W'(1)) |=> core_resume && !wake_busy;
  endproperty
  a_resume_end: assert property (p_resume_end) else $error("slow resume miss");

  property p_am_decode;
    @(posedge clk_sys) disable iff (!rst_n)
    (power_mode != SSMC_PM_LPM234 && low_sup_enable && low_sup_full_perf)
      |=> low_sup_state == SSMC_FULL;
  endproperty
  a_am_decode: assert property (p_am_decode) else $error("am decode wrong");
  property p_deep_auto;
    @(posedge clk_sys) disable iff (!rst_n)
    (deep && low_sup_enable && low_sup_lpm_keep && low_sup_full_perf && low_auto_control)
      |=> low_sup_state == SSMC_NORMAL;
  endproperty
  a_deep_auto: assert property (p_deep_auto) else $error("auto decode wrong");

  property p_settle;
    @(posedge clk_sys) disable iff (!rst_n)
    ctl_write |=> low_settle_flag && high_settle_flag;
  endproperty
  a_settle: assert property (p_settle) else $error("settle flag missing");

  property p_ovp;
    @(posedge clk_sys) disable iff (!rst_n)
    (overvoltage_prot_enable && hm_on && high_over_event) |=> por_req;
  endproperty
  a_ovp: assert property (p_ovp) else $error("ovp reset missing");

  property p_hm_idle;
    @(posedge clk_sys) disable iff (!rst_n)
    (deep && high_auto_control) |=> high_mon_state == SSMC_OFF;
  endproperty
  a_hm_idle: assert property (p_hm_idle) else $error("high monitor active");
  // An overvoltage trip in the same cycle may legally raise the reset too
  property p_low_irq;
    @(posedge clk_sys) disable iff (!rst_n)
    (low_event && !low_event_reset_sel && !high_over_event) |=> low_event_irq && !por_req [*1];
  endproperty
  a_low_irq: assert property (p_low_irq) else $error("low event path");

  c_slow_wake: cover property (@(posedge clk_sys) disable iff (!rst_n)
    wake_busy ##1 core_resume);
  c_fast_wake: cover property (@(posedge clk_sys) disable iff (!rst_n)
    wake_req && !slow_wake_sel ##1 core_resume);
  c_settle_end: cover property (@(posedge clk_sys) disable iff (!rst_n)
    low_settle_flag ##1 !low_settle_flag);
  c_ovp: cover property (@(posedge clk_sys) disable iff (!rst_n) por_req);

endmodule // ssmc_top

// >>> tb/tb_top.sv
`timescale 1ns/10ps
// Compare one value against its expectation and count the result
`define CHK(got, exp) begin checked++; if ((got) !== (exp)) begin num_errors++; \
  $display("mismatch at %0t: got %0h expected %0h", $time, got, exp); end end
module tb_top;
  import ssmc_pkg::*;
  ////////////////////////////////////////////////////////////////////////////////
  localparam int unsigned SLOW = 8;     // Short wake hold keeps the run brief
  localparam int unsigned SETL = 8;     // Short settle delay, same reason
  logic        clk_sys = 1'b0;          // System clock, 25 ns period
  logic        arst_n;                  // Async reset, active low
  ssmc_pmode_t power_mode;              // Current power mode
  logic        en, keep, fp, autoc;     // One config drives both sides alike
  logic        ovp_en, ctl_write, wake_req, low_event, over_event, rst_sel;
  logic [1:0]  low_sup_state, low_mon_state, high_sup_state, high_mon_state;
  logic        slow_wake_sel, core_resume, low_settle_flag, high_settle_flag;
  logic        por_req, low_event_irq;
  int          num_errors = 0;          // Mismatches seen
  int          checked = 0;             // Comparisons made
  int          cycles = 0;              // Watchdog count
  int          por_cnt = 0, irq_cnt = 0, res_cnt = 0;  // Pulse tallies
  int          lat, lat_fast;           // Wake latencies
  // Rows: mode, en, keep, fp, auto, then low sup, low mon, high mon states
  logic [11:0] rows [12] = '{12'h000, 12'h215, 12'h2aa, 12'h6ea, 12'h980, 12'ha05,
                             12'hac4, 12'hb15, 12'hb40, 12'hbaa, 12'hbd4, 12'heea};
  ////////////////////////////////////////////////////////////////////////////////
  ssmc_top #(.SLOW_CYC(SLOW), .SETTLE_LEN(SETL)) DUT (
    .clk_sys(clk_sys), .arst_n(arst_n), .power_mode(power_mode),
    .low_sup_enable(en), .low_sup_lpm_keep(keep), .low_sup_full_perf(fp),
    .low_mon_enable(en), .low_mon_full_perf(fp), .low_auto_control(autoc),
    .high_sup_enable(en), .high_sup_lpm_keep(keep), .high_sup_full_perf(fp),
    .high_mon_enable(en), .high_mon_full_perf(fp), .high_auto_control(autoc),
    .overvoltage_prot_enable(ovp_en), .ctl_write(ctl_write), .wake_req(wake_req),
    .low_event(low_event), .high_over_event(over_event), .low_event_reset_sel(rst_sel),
    .low_sup_state(low_sup_state), .low_mon_state(low_mon_state),
    .high_sup_state(high_sup_state), .high_mon_state(high_mon_state),
    .slow_wake_sel(slow_wake_sel), .core_resume(core_resume),
    .low_settle_flag(low_settle_flag), .high_settle_flag(high_settle_flag),
    .por_req(por_req), .low_event_irq(low_event_irq));
  ////////////////////////////////////////////////////////////////////////////////
  // Clock toggles every half period
  always #12.5 clk_sys = ~clk_sys;
  // Pulse tallies and a watchdog against hangs
  always @(posedge clk_sys) begin
    cycles++;
    if (por_req === 1'b1) por_cnt++;
    if (low_event_irq === 1'b1) irq_cnt++;
    if (core_resume === 1'b1) res_cnt++;
    if (cycles == 4000) begin
      num_errors++;
      finish_test();
    end
  end
  // Apply one configuration and let the registered outputs follow
  task automatic cfg(input logic [5:0] c);
    @(negedge clk_sys);
    // No mode change while a settle flag still stands
    while (low_settle_flag || high_settle_flag) @(negedge clk_sys);
    power_mode = ssmc_pmode_t'(c[5:4]);
    {en, keep, fp, autoc} = c[3:0];
    repeat (3) @(negedge clk_sys);
  endtask
  // One-cycle pulse: 0 wake, 1 low event, 2 over event, 3 control write
  task automatic pulse(input int k);
    @(negedge clk_sys);
    if (k == 0) wake_req = 1'b1;
    else if (k == 1) low_event = 1'b1;
    else if (k == 2) over_event = 1'b1;
    else ctl_write = 1'b1;
    @(negedge clk_sys);
    {wake_req, low_event, over_event, ctl_write} = 4'h0;
  endtask
  // Wake request; latency counted in cycles until the resume pulse
  task automatic wake(output int l);
    int r0;
    r0 = res_cnt;
    pulse(0);
    l = 1;
    while (res_cnt == r0 && l < 40) begin
      @(negedge clk_sys);
      l++;
    end
    repeat (3) @(negedge clk_sys);
    `CHK(res_cnt - r0, 1)
  endtask
  // Counts line, then the verdict
  task automatic finish_test();
    $display("errors %0d, comparisons %0d", num_errors, checked);
    if (num_errors == 0 && checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    arst_n = 1'b0;
    power_mode = SSMC_PM_ACTIVE;
    {en, keep, fp, autoc, ovp_en, ctl_write, wake_req} = 7'h00;
    {low_event, over_event, rst_sel} = 3'h0;
    repeat (4) @(negedge clk_sys);
    `CHK({low_settle_flag, por_req, core_resume, low_sup_state}, 5'h00)
    arst_n = 1'b1;
    repeat (4) @(negedge clk_sys);
    // Decode table: active, LPM0/1 and LPM2/3/4, both sides
    foreach (rows[i]) begin
      cfg(rows[i][11:6]);
      `CHK(low_sup_state, rows[i][5:4])
      `CHK(high_sup_state, rows[i][5:4])
      `CHK(low_mon_state, rows[i][3:2])
      `CHK(high_mon_state, rows[i][1:0])
      `CHK(slow_wake_sel, rows[i][9] & ~rows[i][7])
    end
    // Settle flags, then a second write restarting the delay
    pulse(3);
    @(negedge clk_sys);
    ctl_write = 1'b1;
    @(negedge clk_sys);
    ctl_write = 1'b0;
    repeat (2) @(negedge clk_sys);
    `CHK({low_settle_flag, high_settle_flag}, 2'h3)
    repeat (SETL) @(negedge clk_sys);
    `CHK({low_settle_flag, high_settle_flag}, 2'h0)
    ctl_write = 1'b1;
    @(negedge clk_sys);
    ctl_write = 1'b0;
    repeat (4) @(negedge clk_sys);
    ctl_write = 1'b1;
    @(negedge clk_sys);
    ctl_write = 1'b0;
    repeat (SETL - 2) @(negedge clk_sys);
    `CHK({low_settle_flag, high_settle_flag}, 2'h3)
    repeat (6) @(negedge clk_sys);
    `CHK({low_settle_flag, high_settle_flag}, 2'h0)
    // Fast wake with full performance, slow wake with normal mode
    cfg(6'h2a);
    wake(lat_fast);
    // Hold off after a fast wake before switching to normal mode
    repeat (SLOW) @(negedge clk_sys);
    cfg(6'h28);
    `CHK(slow_wake_sel, 1'b1)
    wake(lat);
    `CHK(lat - lat_fast, SLOW)
    // High side kept on in deep mode; a wake during the hold is refused
    cfg(6'h2c);
    lat = res_cnt;
    pulse(0);
    pulse(0);
    repeat (7) @(negedge clk_sys);
    `CHK(res_cnt - lat, 1)
    // Low event goes to reset or to interrupt by the select bit
    rst_sel = 1'b1;
    pulse(1);
    repeat (3) @(negedge clk_sys);
    `CHK({por_cnt, irq_cnt}, {32'd1, 32'd0})
    rst_sel = 1'b0;
    pulse(1);
    repeat (3) @(negedge clk_sys);
    `CHK({por_cnt, irq_cnt}, {32'd1, 32'd1})
    // Overvoltage: off gives nothing, on gives reset, auto in LPM idles it
    cfg(6'h08);
    pulse(2);
    repeat (3) @(negedge clk_sys);
    `CHK(por_cnt, 1)
    ovp_en = 1'b1;
    pulse(2);
    repeat (3) @(negedge clk_sys);
    `CHK(por_cnt, 2)
    cfg(6'h2d);
    pulse(2);
    repeat (3) @(negedge clk_sys);
    `CHK(por_cnt, 2)
    finish_test();
  end
endmodule // tb_top
